//--- inc/fuse_cfg_consts.svh
// constants for the configuration fuse and self-programming timing block
// assumes inclusion by bare name from package and design files
`ifndef FUSE_CFG_CONSTS_SVH
`define FUSE_CFG_CONSTS_SVH

// register port offsets (8-bit data, byte-wide registers)
`define REG_PROG_CTL 8'h00
`define REG_PROG_PAGE 8'h01
`define REG_PROG_LOCKDATA 8'h02
`define REG_FUSE_EXT 8'h03
`define REG_FUSE_HIGH 8'h04
`define REG_LOCK_BITS 8'h05

// self-programming control register fields
`define CTL_START 0
`define CTL_OP_LO 1
`define CTL_OP_HI 2
`define CTL_BUSY 3
`define CTL_DONE 4
`define CTL_ERR 5
`define CTL_RWW_BUSY 6

// extended configuration byte fields
`define EXT_RESET_VEC 0
`define EXT_BOOT_SIZE_LO 1
`define EXT_BOOT_SIZE_HI 2

// high configuration byte fields
`define HIGH_EE_KEEP 3
`define HIGH_WDT_ON 4
`define HIGH_SERIAL_PROG 5
`define HIGH_DEBUG 6
`define HIGH_RST_DIS 7

// factory values of the configuration storage (0 = programmed)
`define EXT_DEFAULT 8'hf9
`define HIGH_DEFAULT 8'hdf
`define LOCK_DEFAULT 8'hff

// programmer port byte selects
`define PSEL_EXT 2'h0
`define PSEL_HIGH 2'h1
`define PSEL_LOCK 2'h2

// write timing, counted in ticks of the calibrated RC oscillator
`define PROG_MIN_US 3700
`define PROG_MAX_US 4500
`define RC_FREQ_KHZ 8000
`define PROG_TICKS_MIN ((`PROG_MIN_US * `RC_FREQ_KHZ + 999) / 1000)
`define PROG_TICKS_MAX ((`PROG_MAX_US * `RC_FREQ_KHZ) / 1000)
`define PROG_CNT_W 16

`endif

//--- inc/fuse_cfg_pkg.sv
// types shared by the configuration fuse and self-programming files
// assumes fuse_cfg_consts.svh is on the include path
package fuse_cfg_pkg;
  `include "fuse_cfg_consts.svh"

  typedef enum logic [1:0] {
    OP_PAGE_ERASE,
    OP_PAGE_WRITE,
    OP_LOCK_WRITE,
    OP_ILLEGAL
  } op_kind_t;

  typedef enum logic {
    ENG_IDLE,
    ENG_RUN
  } eng_state_t;
endpackage

//--- design/prog_timer.sv
// tick counter that times one non-volatile write
// assumes rcTick is a one-cycle pulse per RC oscillator period
`timescale 1ns/1ps
`include "fuse_cfg_consts.svh"
module prog_timer #(
  parameter logic [`PROG_CNT_W-1:0] TICKS = `PROG_CNT_W'(`PROG_TICKS_MIN)
) (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic porNrst,
  // control
  input wire logic start,
  input wire logic rcTick,
  // status
  output logic running,
  output logic done
);
  logic [`PROG_CNT_W-1:0] cnt_q, cnt_d;
  logic run_q, run_d;
  logic done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    if (start && !run_q) begin
      cnt_d = '0;
      run_d = 1'b1;
    end else if (run_q && rcTick) begin
      if (cnt_q == TICKS - 1'b1) begin
        run_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge porNrst) begin
    if (!porNrst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done_q <= done_d;
    end
  end

  assign running = run_q;
  assign done = done_q;
endmodule // prog_timer

//--- design/fuse_store.sv
// non-volatile storage of the configuration and lock bytes
// assumes porNrst models the factory state; programmed bits read as zero
`timescale 1ns/1ps
`include "fuse_cfg_consts.svh"
module fuse_store (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic porNrst,
  // write ports, one per byte
  input wire logic extWe,
  input wire logic [7:0] extWdata,
  input wire logic highWe,
  input wire logic [7:0] highWdata,
  input wire logic lockWe,
  input wire logic [7:0] lockWdata,
  // stored values
  output logic [7:0] extQ,
  output logic [7:0] highQ,
  output logic [7:0] lockQ
);
  logic [7:0] ext_q, ext_d, high_q, high_d, lock_q, lock_d;

  always_comb begin
    ext_d = extWe ? extWdata : ext_q;
    high_d = highWe ? highWdata : high_q;
    lock_d = lockWe ? lockWdata : lock_q;
  end

  always_ff @(posedge ref_clk or negedge porNrst) begin
    if (!porNrst) begin
      ext_q <= `EXT_DEFAULT;
      high_q <= `HIGH_DEFAULT;
      lock_q <= `LOCK_DEFAULT;
    end else begin
      ext_q <= ext_d;
      high_q <= high_d;
      lock_q <= lock_d;
    end
  end

  assign extQ = ext_q;
  assign highQ = high_q;
  assign lockQ = lock_q;
endmodule // fuse_store

//--- design/fuse_config_and_selfprog_timing.sv
// configuration fuses, lock bits and self-programming write timing
// assumes rcTick pulses once per calibrated RC period, porNrst only at
// power-up, nrst for every other reset; all inputs synchronous to ref_clk
//
// Behaviour
// - self-program writes timed by RC oscillator ticks
// - each write lasts 3.7 to 4.5 ms
// - nrst never aborts a running write; power-on reset does
// - read-while-write busy flag always reads zero
// - boot size selector defaults programmed, zero
// - extended bit 0 selects reset vector
// - high bit 7 disables external reset
// - high bit 6 enables single-wire debug
// - high bit 5 enables serial programming
// - serial-programming bit locked in serial mode
// - high bit 4 forces watchdog on
// - high bit 3 keeps EEPROM on erase
// - programmed bits read zero, unprogrammed one
`timescale 1ns/1ps
`include "fuse_cfg_consts.svh"
module fuse_config_and_selfprog_timing #(
  parameter logic [`PROG_CNT_W-1:0] PROG_TICKS = `PROG_CNT_W'(`PROG_TICKS_MIN)
) (
  // clock and resets
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic porNrst,
  // calibrated RC oscillator tick
  input wire logic rcTick,
  // software register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // external programmer port
  input wire logic progMode,
  input wire logic progWr,
  input wire logic progRd,
  input wire logic [1:0] progSel,
  input wire logic [7:0] progWdata,
  output logic [7:0] progRdata,
  // flash array control
  output logic flashOpBusy,
  output fuse_cfg_pkg::op_kind_t flashOpKind,
  output logic [7:0] flashOpPage,
  output logic flashOpDone,
  // latched configuration
  output logic [1:0] boot_area_size_sel,
  output logic reset_vector_sel,
  output logic ext_reset_disable,
  output logic onewire_debug_enable,
  output logic serial_prog_enable,
  output logic watchdog_force_on,
  output logic eeprom_keep_on_erase,
  output logic rww_section_busy
);
  import fuse_cfg_pkg::*;
  // storage and timer wiring
  logic [7:0] extStore, highStore, lockStore;
  logic extWe, highWe, lockWe;
  logic [7:0] extWdata, highWdata, lockWdata;
  logic timerStart, timerRunning, timerDone;
  // software-side registers, reset by nrst only, not by porNrst
  logic [7:0] page_q, page_d;
  logic [7:0] lockData_q, lockData_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic [7:0] regRdata_q, regRdata_d;

  // write engine, survives nrst so only power-on reset stops a started write
  eng_state_t eng_q, eng_d;
  op_kind_t opKind_q, opKind_d;
  logic [7:0] opPage_q, opPage_d;
  logic [7:0] opLock_q, opLock_d;
  logic opDone_q, opDone_d;

  // configuration latched from storage
  logic loadPend_q, loadPend_d;
  logic [1:0] bootSz_q, bootSz_d;
  logic resetVec_q, resetVec_d;
  logic rstDis_q, rstDis_d;
  logic dbgEn_q, dbgEn_d;
  logic serial_prog_enable_q, serial_prog_enable_d;
  logic watchdog_force_on_q, watchdog_force_on_d;
  logic eeKeep_q, eeKeep_d;

  // programmer read data
  logic [7:0] progRdata_q, progRdata_d;

  // request decode
  logic ctlWr, startReq, startOk;
  op_kind_t reqKind;

  assign ctlWr = regWr && (regAddr == `REG_PROG_CTL);
  assign reqKind = op_kind_t'(regWdata[`CTL_OP_HI:`CTL_OP_LO]);
  assign startReq = ctlWr && regWdata[`CTL_START];
  // a start while busy or with an unused op code is refused
  assign startOk = startReq && (eng_q == ENG_IDLE) &&
                   (reqKind != OP_ILLEGAL);

  prog_timer #(
    .TICKS(PROG_TICKS)
  ) u_timer (
    .ref_clk(ref_clk),
    .porNrst(porNrst),
    .start(timerStart),
    .rcTick(rcTick),
    .running(timerRunning),
    .done(timerDone)
  );

  fuse_store u_store (
    .ref_clk(ref_clk),
    .porNrst(porNrst),
    .extWe(extWe),
    .extWdata(extWdata),
    .highWe(highWe),
    .highWdata(highWdata),
    .lockWe(lockWe),
    .lockWdata(lockWdata),
    .extQ(extStore),
    .highQ(highStore),
    .lockQ(lockStore)
  );

  // write engine
  always_comb begin
    eng_d = eng_q;
    opKind_d = opKind_q;
    opPage_d = opPage_q;
    opLock_d = opLock_q;
    opDone_d = 1'b0;
    timerStart = 1'b0;
    unique case (eng_q)
      ENG_IDLE: begin
        if (startOk) begin
          eng_d = ENG_RUN;
          opKind_d = reqKind;
          opPage_d = page_q;
          opLock_d = lockData_q;
          timerStart = 1'b1;
        end
      end
      ENG_RUN: begin
        // duration set only by RC ticks, never by ref_clk cycles
        if (timerDone) begin
          eng_d = ENG_IDLE;
          opDone_d = 1'b1;
        end
      end
    endcase
  end

  // power-on reset only: nrst does not abort a write in progress
  always_ff @(posedge ref_clk or negedge porNrst) begin
    if (!porNrst) begin
      eng_q <= ENG_IDLE;
      opKind_q <= OP_PAGE_ERASE;
      opPage_q <= 8'h00;
      opLock_q <= 8'hff;
      opDone_q <= 1'b0;
    end else begin
      eng_q <= eng_d;
      opKind_q <= opKind_d;
      opPage_q <= opPage_d;
      opLock_q <= opLock_d;
      opDone_q <= opDone_d;
    end
  end

  // storage writes from the engine and the external programmer
  always_comb begin
    extWe = 1'b0;
    highWe = 1'b0;
    lockWe = 1'b0;
    extWdata = extStore;
    highWdata = highStore;
    lockWdata = lockStore;
    if (progMode && progWr) begin
      unique case (progSel)
        `PSEL_EXT: begin
          extWe = 1'b1;
          extWdata = progWdata;
        end
        `PSEL_HIGH: begin
          highWe = 1'b1;
          highWdata = progWdata;
          // keeps the programmer from locking itself out
          highWdata[`HIGH_SERIAL_PROG] =
            highStore[`HIGH_SERIAL_PROG];
        end
        `PSEL_LOCK: begin
          lockWe = 1'b1;
          lockWdata = lockStore & progWdata;
        end
        default: begin
        end
      endcase
    end
    // lock bits only move towards programmed, so both writers combine
    if (timerDone && (opKind_q == OP_LOCK_WRITE)) begin
      lockWe = 1'b1;
      lockWdata = lockWdata & opLock_q;
    end
  end

  // software registers
  always_comb begin
    page_d = page_q;
    lockData_d = lockData_q;
    done_d = done_q;
    err_d = err_q;
    if (regWr && (regAddr == `REG_PROG_PAGE)) begin
      page_d = regWdata;
    end
    if (regWr && (regAddr == `REG_PROG_LOCKDATA)) begin
      lockData_d = regWdata;
    end
    // write one to clear; a same-cycle event wins over the clear
    if (ctlWr && regWdata[`CTL_DONE]) begin
      done_d = 1'b0;
    end
    if (ctlWr && regWdata[`CTL_ERR]) begin
      err_d = 1'b0;
    end
    if (opDone_q) begin
      done_d = 1'b1;
    end
    if (startReq && !startOk) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      page_q <= 8'h00;
      lockData_q <= 8'hff;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      page_q <= page_d;
      lockData_q <= lockData_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  // register read data, valid only in the cycle after the read strobe
  always_comb begin
    regRdata_d = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        `REG_PROG_CTL: begin
          regRdata_d[`CTL_OP_HI:`CTL_OP_LO] = opKind_q;
          regRdata_d[`CTL_BUSY] = (eng_q == ENG_RUN);
          regRdata_d[`CTL_DONE] = done_q;
          regRdata_d[`CTL_ERR] = err_q;
          regRdata_d[`CTL_RWW_BUSY] = 1'b0;
        end
        `REG_PROG_PAGE: regRdata_d = page_q;
        `REG_PROG_LOCKDATA: regRdata_d = lockData_q;
        // active-high settings re-encoded, zero meaning programmed
        `REG_FUSE_EXT: begin
          regRdata_d = 8'hff;
          regRdata_d[`EXT_BOOT_SIZE_HI:`EXT_BOOT_SIZE_LO] = bootSz_q;
          regRdata_d[`EXT_RESET_VEC] = resetVec_q;
        end
        `REG_FUSE_HIGH: begin
          regRdata_d = highStore;
          regRdata_d[`HIGH_RST_DIS] = ~rstDis_q;
          regRdata_d[`HIGH_DEBUG] = ~dbgEn_q;
          regRdata_d[`HIGH_SERIAL_PROG] = ~serial_prog_enable_q;
          regRdata_d[`HIGH_WDT_ON] = ~watchdog_force_on_q;
          regRdata_d[`HIGH_EE_KEEP] = ~eeKeep_q;
        end
        `REG_LOCK_BITS: regRdata_d = lockStore;
        default: regRdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata_q <= 8'h00;
    end else begin
      regRdata_q <= regRdata_d;
    end
  end

  // configuration latch: defaults during reset, storage copied once after
  always_comb begin
    loadPend_d = 1'b0;
    bootSz_d = bootSz_q;
    resetVec_d = resetVec_q;
    rstDis_d = rstDis_q;
    dbgEn_d = dbgEn_q;
    serial_prog_enable_d = serial_prog_enable_q;
    watchdog_force_on_d = watchdog_force_on_q;
    eeKeep_d = eeKeep_q;
    if (loadPend_q) begin
      bootSz_d = extStore[`EXT_BOOT_SIZE_HI:`EXT_BOOT_SIZE_LO];
      resetVec_d = extStore[`EXT_RESET_VEC];
      rstDis_d = ~highStore[`HIGH_RST_DIS];
      dbgEn_d = ~highStore[`HIGH_DEBUG];
      serial_prog_enable_d = ~highStore[`HIGH_SERIAL_PROG];
      watchdog_force_on_d = ~highStore[`HIGH_WDT_ON];
      eeKeep_d = ~highStore[`HIGH_EE_KEEP];
    end
  end

  // the storage cannot be sampled under an asynchronous reset, so the
  // factory defaults stand until the first edge after release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loadPend_q <= 1'b1;
      bootSz_q <= 2'(`EXT_DEFAULT >> `EXT_BOOT_SIZE_LO);
      resetVec_q <= 1'b1;
      rstDis_q <= 1'b0;
      dbgEn_q <= 1'b0;
      serial_prog_enable_q <= 1'b1;
      watchdog_force_on_q <= 1'b0;
      eeKeep_q <= 1'b0;
    end else begin
      loadPend_q <= loadPend_d;
      bootSz_q <= bootSz_d;
      resetVec_q <= resetVec_d;
      rstDis_q <= rstDis_d;
      dbgEn_q <= dbgEn_d;
      serial_prog_enable_q <= serial_prog_enable_d;
      watchdog_force_on_q <= watchdog_force_on_d;
      eeKeep_q <= eeKeep_d;
    end
  end

  // programmer reads show raw storage, not the latched copy
  always_comb begin
    progRdata_d = 8'h00;
    if (progMode && progRd) begin
      unique case (progSel)
        `PSEL_EXT: progRdata_d = extStore;
        `PSEL_HIGH: progRdata_d = highStore;
        `PSEL_LOCK: progRdata_d = lockStore;
        default: progRdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      progRdata_q <= 8'h00;
    end else begin
      progRdata_q <= progRdata_d;
    end
  end

  assign regRdata = regRdata_q;
  assign progRdata = progRdata_q;
  assign flashOpBusy = timerRunning;
  assign flashOpKind = opKind_q;
  assign flashOpPage = opPage_q;
  assign flashOpDone = opDone_q;
  assign boot_area_size_sel = bootSz_q;
  assign reset_vector_sel = resetVec_q;
  assign ext_reset_disable = rstDis_q;
  assign onewire_debug_enable = dbgEn_q;
  assign serial_prog_enable = serial_prog_enable_q;
  assign watchdog_force_on = watchdog_force_on_q;
  assign eeprom_keep_on_erase = eeKeep_q;
  // no read-while-write section on this part
  assign rww_section_busy = 1'b0;
endmodule // fuse_config_and_selfprog_timing

//--- dv/fuse_cfg_properties.sv
// assertions for the fuse configuration and self-program timing block
// assumes it is bound to the top module; rcTick is a one-cycle pulse
`timescale 1ns/1ps
`include "fuse_cfg_consts.svh"
module fuse_cfg_properties #(
  parameter logic [`PROG_CNT_W-1:0] PROG_TICKS = `PROG_CNT_W'(`PROG_TICKS_MIN)
) (
  // clock and resets
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic porNrst,
  input wire logic rcTick,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // write engine
  input wire logic flashOpBusy,
  input wire logic flashOpDone,
  // latched configuration
  input wire logic [1:0] boot_area_size_sel,
  input wire logic reset_vector_sel,
  input wire logic ext_reset_disable,
  input wire logic onewire_debug_enable,
  input wire logic serial_prog_enable,
  input wire logic watchdog_force_on,
  input wire logic eeprom_keep_on_erase,
  input wire logic rww_section_busy
);
  logic [`PROG_CNT_W-1:0] tickCnt_q, tickCnt_d;
  logic [4:0] highCfg;
  assign highCfg = {ext_reset_disable, onewire_debug_enable,
    serial_prog_enable, watchdog_force_on, eeprom_keep_on_erase};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!porNrst);

  // ticks seen while busy; a plain reset must not restart this count
  always_comb begin
    tickCnt_d = tickCnt_q;
    if (!flashOpBusy)
      tickCnt_d = '0;
    else if (rcTick)
      tickCnt_d = tickCnt_q + 1'h1;
  end
  always_ff @(posedge ref_clk or negedge porNrst) begin
    if (!porNrst)
      tickCnt_q <= '0;
    else
      tickCnt_q <= tickCnt_d;
  end

  property p_rwwZero;
    rww_section_busy == 1'h0;
  endproperty
  a_rwwZero: assert property (p_rwwZero)
    else $error("rww busy flag not zero");
  property p_endOnTick;
    $fell(flashOpBusy) |-> $past(rcTick) || $past(rcTick, 2)
      || $past(rcTick, 3);
  endproperty
  a_endOnTick: assert property (p_endOnTick)
    else $error("write ended away from an rc tick");
  property p_tickCount;
    $fell(flashOpBusy) |-> tickCnt_q >= PROG_TICKS - 1'h1
      && tickCnt_q <= PROG_TICKS + 1'h1;
  endproperty
  a_tickCount: assert property (p_tickCount)
    else $error("write length in ticks wrong");
  property p_doneFollows;
    $fell(flashOpBusy) |-> ##[0:2] flashOpDone;
  endproperty
  a_doneFollows: assert property (p_doneFollows)
    else $error("no done pulse after write");
  property p_cfgInReset;
    !nrst |-> boot_area_size_sel == 2'h0 && reset_vector_sel
      && highCfg == 5'h04;
  endproperty
  a_cfgInReset: assert property (p_cfgInReset)
    else $error("config not at defaults in reset");
  property p_cfgHeld;
    disable iff (!nrst) $past(nrst) && $past(nrst, 2)
      |-> $stable({boot_area_size_sel, reset_vector_sel, highCfg});
  endproperty
  a_cfgHeld: assert property (p_cfgHeld)
    else $error("config changed outside reset");
  property p_highRead;
    disable iff (!nrst) regRd && regAddr == `REG_FUSE_HIGH && $past(nrst)
      |=> regRdata[7:3] == ~highCfg;
  endproperty
  a_highRead: assert property (p_highRead)
    else $error("high byte read polarity wrong");
  property p_extRead;
    disable iff (!nrst) regRd && regAddr == `REG_FUSE_EXT && $past(nrst)
      |=> regRdata == {5'h1f, boot_area_size_sel, reset_vector_sel};
  endproperty
  a_extRead: assert property (p_extRead)
    else $error("ext byte read wrong");

  c_write: cover property ($rose(flashOpBusy));
  c_rstInWrite: cover property (flashOpBusy && !nrst);
  c_highRead: cover property (regRd && regAddr == `REG_FUSE_HIGH);
endmodule // fuse_cfg_properties

bind fuse_config_and_selfprog_timing fuse_cfg_properties #(
  .PROG_TICKS(PROG_TICKS)
) fuse_cfg_properties_i (.ref_clk, .nrst, .porNrst, .rcTick, .regAddr,
  .regRd, .regRdata, .flashOpBusy, .flashOpDone, .boot_area_size_sel,
  .reset_vector_sel, .ext_reset_disable, .onewire_debug_enable,
  .serial_prog_enable, .watchdog_force_on, .eeprom_keep_on_erase,
  .rww_section_busy);

//--- dv/tb_fuse_config_and_selfprog_timing.sv
// self-checking bench for the fuse config and self-program timing block
// assumes package and design compiled first; rc tick every 31 clocks
`timescale 1ns/1ps
`include "fuse_cfg_consts.svh"
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin nFail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_fuse_config_and_selfprog_timing;
  import fuse_cfg_pkg::*;
  localparam logic [15:0] TICKS = 16'h0004;
  localparam int RC_DIV = 31;
  logic ref_clk = 0, nrst = 0, porNrst = 0, rcTick = 0;
  logic regWr = 0, regRd = 0, progMode = 0, progWr = 0, progRd = 0;
  logic [7:0] regAddr = 0, regWdata = 0, progWdata = 0, regRdata;
  logic [7:0] progRdata, flashOpPage, rd, e, h, l;
  logic [1:0] progSel = 0, boot_area_size_sel;
  logic flashOpBusy, flashOpDone, reset_vector_sel, ext_reset_disable;
  logic onewire_debug_enable, serial_prog_enable, watchdog_force_on;
  logic eeprom_keep_on_erase, rww_section_busy;
  op_kind_t flashOpKind;
  logic [7:0] extM, highM, lockM, extL, highL;
  int nFail = 0, nTests = 0, rcCnt = 0;

  fuse_config_and_selfprog_timing #(.PROG_TICKS(TICKS))
    fuse_config_and_selfprog_timing_i (.ref_clk, .nrst, .porNrst, .rcTick,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .progMode, .progWr,
    .progRd, .progSel, .progWdata, .progRdata, .flashOpBusy, .flashOpKind,
    .flashOpPage, .flashOpDone, .boot_area_size_sel, .reset_vector_sel,
    .ext_reset_disable, .onewire_debug_enable, .serial_prog_enable,
    .watchdog_force_on, .eeprom_keep_on_erase, .rww_section_busy);

  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    rcCnt <= (rcCnt == RC_DIV - 1) ? 0 : rcCnt + 1;
    rcTick <= (rcCnt == RC_DIV - 1);
  end

  task automatic summarize;
    $display("tests %0d failures %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge ref_clk);
    regWr <= 1'h0;
  endtask
  task automatic rdReg(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge ref_clk);
    regRd <= 1'h0;
    #1 rd = regRdata;
  endtask
  task automatic pg(input logic m, w, input logic [1:0] s,
      input logic [7:0] d);
    @(posedge ref_clk);
    progMode <= m;
    progWr <= w;
    progRd <= !w;
    progSel <= s;
    progWdata <= d;
    @(posedge ref_clk);
    progWr <= 1'h0;
    progRd <= 1'h0;
    #1 rd = progRdata;
  endtask
  task automatic rst(input logic por);
    @(posedge ref_clk);
    nrst <= 1'h0;
    porNrst <= !por;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'h1;
    porNrst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    if (por) begin
      extM = 8'hf9;
      highM = 8'hdf;
      lockM = 8'hff;
    end
    extL = extM;
    highL = highM;
  endtask
  task automatic chkCfg;
    `CHK(boot_area_size_sel, extL[2:1])
    `CHK(reset_vector_sel, extL[0])
    `CHK(ext_reset_disable, ~highL[7])
    `CHK(onewire_debug_enable, ~highL[6])
    `CHK(serial_prog_enable, ~highL[5])
    `CHK(watchdog_force_on, ~highL[4])
    `CHK(eeprom_keep_on_erase, ~highL[3])
    `CHK(rww_section_busy, 1'h0)
    rdReg(`REG_FUSE_EXT);
    `CHK(rd, {5'h1f, extL[2:0]})
    rdReg(`REG_FUSE_HIGH);
    `CHK(rd[7:3], highL[7:3])
    rdReg(`REG_LOCK_BITS);
    `CHK(rd, lockM)
    rdReg(8'h80);
    `CHK(rd, 8'h00)
  endtask
  task automatic selfProg(input logic [1:0] op, input logic mid, dbl);
    logic [7:0] pg8, ld;
    longint t0;
    int n;
    pg8 = 8'($urandom);
    ld = 8'($urandom);
    wr(`REG_PROG_PAGE, pg8);
    wr(`REG_PROG_LOCKDATA, ld);
    wr(`REG_PROG_CTL, {5'h00, op, 1'h1});
    #1 t0 = $time;
    `CHK(flashOpBusy, 1'h1)
    `CHK(flashOpKind, op_kind_t'(op))
    `CHK(flashOpPage, pg8)
    rdReg(`REG_PROG_CTL);
    `CHK(rd & 8'h4e, {4'h0, 1'h1, op, 1'h0})
    rdReg(`REG_PROG_PAGE);
    `CHK(rd, pg8)
    rdReg(`REG_PROG_LOCKDATA);
    `CHK(rd, ld)
    if (dbl)
      wr(`REG_PROG_CTL, 8'h03);
    if (mid) begin
      @(posedge ref_clk);
      nrst <= 1'h0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'h1;
    end
    n = 0;
    while (flashOpDone !== 1'h1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = int'(($time - t0) / 4);
    `CHK(flashOpDone, 1'h1)
    `CHK(n >= (TICKS - 1) * RC_DIV && n <= TICKS * RC_DIV + 4, 1'h1)
    if (op == 2'h2)
      lockM = lockM & ld;
    rdReg(`REG_PROG_CTL);
    `CHK(rd & 8'h78, {2'h0, dbl, 5'h10})
    wr(`REG_PROG_CTL, 8'h30);
    rdReg(`REG_LOCK_BITS);
    `CHK(rd, lockM)
  endtask

  initial begin
    void'($urandom(32'hde009630));
    rst(1'h1);
    chkCfg();
    for (int i = 0; i < 4; i++) begin
      e = 8'($urandom) | 8'hf8;
      h = 8'($urandom);
      h[5] = ~highM[5];
      l = 8'($urandom) | 8'hf0;
      pg(1'h0, 1'h1, `PSEL_LOCK, 8'h00);
      pg(1'h1, 1'h1, `PSEL_EXT, e);
      pg(1'h1, 1'h1, `PSEL_HIGH, h);
      pg(1'h1, 1'h1, 2'h3, 8'h00);
      pg(1'h1, 1'h1, `PSEL_LOCK, l);
      extM = e;
      highM = (h & 8'hdf) | (highM & 8'h20);
      lockM = lockM & l;
      pg(1'h1, 1'h0, `PSEL_EXT, 8'h00);
      `CHK(rd, extM)
      pg(1'h1, 1'h0, `PSEL_HIGH, 8'h00);
      `CHK(rd, highM)
      pg(1'h1, 1'h0, `PSEL_LOCK, 8'h00);
      `CHK(rd, lockM)
      chkCfg();
      rst(1'h0);
      chkCfg();
    end
    pg(1'h0, 1'h0, `PSEL_LOCK, 8'h00);
    `CHK(rd, 8'h00)
    for (int k = 0; k < 3; k++)
      selfProg(k[1:0], 1'h0, 1'h0);
    selfProg(2'h2, 1'h1, 1'h0);
    selfProg(2'h0, 1'h0, 1'h1);
    wr(`REG_PROG_CTL, 8'h07);
    rdReg(`REG_PROG_CTL);
    `CHK(rd & 8'h28, 8'h20)
    chkCfg();
    summarize();
  end
  initial begin
    #40000;
    nFail++;
    summarize();
  end
endmodule // tb_fuse_config_and_selfprog_timing
